//--- ars_consts.svh
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH
// rotating subset bases and sizes
`define ARS_INT_ROT_BASE 7'h20
`define ARS_FLT_ROT_BASE 7'h20
`define ARS_CND_ROT_BASE 7'h10
`define ARS_FLT_ROT_SIZE 7'h60
`define ARS_CND_ROT_SIZE 7'h30
`define ARS_ROT_GROUP 7'h08
`define ARS_STK_MAX 7'h60
// file extents
`define ARS_CND_COUNT 7'h40
`define ARS_JMP_COUNT 7'h08
// legacy window inside the integer and float files
`define ARS_COMPAT_LO 7'h08
`define ARS_COMPAT_HI 7'h1F
// frame descriptor write fields
`define ARS_FRM_RSVD_HI 47
`define ARS_FRM_RSVD_LO 38
// float constants and deferred fault encoding
`define ARS_FLT_POS_ZERO 82'h0
`define ARS_FLT_POS_ONE 82'h0FFFF8000000000000000
`define ARS_FLT_DEFER_VAL 82'h1FFFE0000000000000000
// bundle pointer step
`define ARS_BUNDLE_STEP 64'h10
// special register classes
`define ARS_SPR_RSVD_MASK 128'h0000FFFFFFFFFFF80000CEEE80D0FF00
`define ARS_SPR_IGN_MASK 128'hFFFF000000000000FFFF000000000000
`define ARS_SPR_RDONLY 7'h11
`endif

//--- ars_pkg.sv
package ars_pkg;
	typedef enum logic [1:0] {
		ARS_F_INT = 2'h0,
		ARS_F_FLT = 2'h1,
		ARS_F_CND = 2'h2,
		ARS_F_JMP = 2'h3
	} ars_file_t;
	typedef enum logic [1:0] {
		ARS_OK = 2'h0,
		ARS_ILLEGAL = 2'h1,
		ARS_RSVD = 2'h2
	} ars_fault_t;
	typedef struct packed {
		logic [5:0] rrb_cnd;
		logic [6:0] rrb_flt;
		logic [6:0] rrb_int;
		logic [3:0] sor;
		logic [6:0] sol;
		logic [6:0] sof;
	} ars_frame_t;
	typedef struct packed {
		logic valid;
		ars_file_t file;
		logic [6:0] idx;
		logic compat;
	} ars_rd_req_t;
	typedef struct packed {
		logic valid;
		ars_file_t file;
		logic [6:0] idx;
		logic [81:0] data;
		logic tag;
		logic compat;
	} ars_wr_req_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [6:0] idx;
	} ars_spr_req_t;
endpackage : ars_pkg

//--- ars_regfile.sv
// Operation
// - reserved register access raises illegal operation fault, access not done
// - ignored register reads zero, writes dropped without fault
// - unimplemented entry of variable-size set raises reserved register/field fault
// - reserved fields read zero; non-zero write raises reserved fault
// - ignored fields read zero, written values dropped without fault
// - undefined field encoding written raises reserved register/field fault
// - write to read-only register faults illegal, contents kept
// - integer file: 128 entries, 64 data bits plus deferred tag bit
// - integer entry zero reads zero; writing it is illegal operation
// - integer 0-31 static, 32-127 stacked by frame, part rotating
// - float file: 128 entries of 82 bits
// - float entry 0 reads +0, entry 1 +1; writing either faults
// - float 0-31 static, 32-127 rotating
// - float deferred fault stored as special encoding, no tag bit
// - 64 one-bit condition entries; entry 0 reads one, writes dropped
// - condition 0-15 static, 16-63 rotating
// - eight 64-bit jump target registers
// - native bundle pointer is 16-byte aligned, low 4 bits zero
// - bundle pointer readable, not writable; advances or takes branch
// - compat mode pointer is zero-extended 32-bit byte address
// - compat state sits in integer and float entries 8-31
// - compat accesses cannot reach native-only registers
// - rotating integer count is eight times the size field
// - call clears all three rename bases to zero
`timescale 1ns/100ps
`default_nettype none
`include "ars_consts.svh"
module ars_regfile (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// operand read
	input wire ars_pkg::ars_rd_req_t rd_req,
	output logic rd_valid_r,
	output logic [81:0] rd_data_r,
	output logic rd_tag_r,
	output ars_pkg::ars_fault_t rd_fault_r,
	// result write
	input wire ars_pkg::ars_wr_req_t wr_req,
	output logic wr_done_r,
	output ars_pkg::ars_fault_t wr_fault_r,
	// frame descriptor
	input wire logic frm_wr,
	input wire logic [63:0] frm_data,
	input wire logic call,
	output ars_pkg::ars_frame_t frame_r,
	output ars_pkg::ars_fault_t frm_fault_r,
	// bundle pointer
	input wire logic compat_mode,
	input wire logic ptr_adv,
	input wire logic [3:0] ptr_len,
	input wire logic br_taken,
	input wire logic [63:0] br_target,
	output logic [63:0] bundle_pointer_r,
	// special register classification
	input wire ars_pkg::ars_spr_req_t spr_req,
	output ars_pkg::ars_fault_t spr_fault_r,
	output logic spr_fwd_r
);

	// storage
	logic [64:0] integer_reg_file [128];
	logic [81:0] float_reg_file [128];
	logic condition_flag_file [64];
	logic [63:0] jump_target_regs [8];

	// logical to physical index through the rename base
	function automatic logic [6:0] map_idx(ars_pkg::ars_file_t f, logic [6:0] i,
			ars_pkg::ars_frame_t fm);
		logic [6:0] base;
		logic [6:0] size;
		logic [7:0] sum;
		base = 7'h00;
		size = 7'h00;
		sum = 8'h00;
		if (f == ars_pkg::ARS_F_INT) begin
			base = `ARS_INT_ROT_BASE;
			size = {3'h0, fm.sor} * `ARS_ROT_GROUP;
			sum = {1'b0, fm.rrb_int};
		end else if (f == ars_pkg::ARS_F_FLT) begin
			base = `ARS_FLT_ROT_BASE;
			size = `ARS_FLT_ROT_SIZE;
			sum = {1'b0, fm.rrb_flt};
		end else if (f == ars_pkg::ARS_F_CND) begin
			base = `ARS_CND_ROT_BASE;
			size = `ARS_CND_ROT_SIZE;
			sum = {2'h0, fm.rrb_cnd};
		end
		if (i >= base && (i - base) < size) begin
			sum = sum + {1'b0, i - base};
			if (sum >= {1'b0, size})
				sum = sum - {1'b0, size};
			return base + sum[6:0];
		end
		return i; // static part is never renamed
	endfunction : map_idx

	// fault class of a register file access
	function automatic ars_pkg::ars_fault_t chk(ars_pkg::ars_file_t f, logic [6:0] i,
			logic wr, logic cm, ars_pkg::ars_frame_t fm);
		logic in_win;
		in_win = i >= `ARS_COMPAT_LO && i <= `ARS_COMPAT_HI;
		if (cm && !(in_win && (f == ars_pkg::ARS_F_INT || f == ars_pkg::ARS_F_FLT)))
			return ars_pkg::ARS_ILLEGAL;
		if (f == ars_pkg::ARS_F_INT) begin
			if (i >= `ARS_INT_ROT_BASE && (i - `ARS_INT_ROT_BASE) >= fm.sof)
				return ars_pkg::ARS_RSVD;
			if (wr && i == 7'h00)
				return ars_pkg::ARS_ILLEGAL;
		end else if (f == ars_pkg::ARS_F_FLT) begin
			if (wr && i < 7'h02)
				return ars_pkg::ARS_ILLEGAL;
		end else if (f == ars_pkg::ARS_F_CND) begin
			if (i >= `ARS_CND_COUNT)
				return ars_pkg::ARS_ILLEGAL;
		end else if (i >= `ARS_JMP_COUNT) begin
			return ars_pkg::ARS_ILLEGAL;
		end
		return ars_pkg::ARS_OK;
	endfunction : chk

	// read path: constant entries, then storage
	wire [6:0] rd_phys = map_idx(rd_req.file, rd_req.idx, frame_r);
	wire ars_pkg::ars_fault_t rd_chk = chk(rd_req.file, rd_req.idx, 1'b0, rd_req.compat, frame_r);
	wire [64:0] rd_int = (rd_phys == 7'h00) ? 65'h0 : integer_reg_file[rd_phys];
	wire [81:0] rd_flt = (rd_phys == 7'h00) ? `ARS_FLT_POS_ZERO :
		(rd_phys == 7'h01) ? `ARS_FLT_POS_ONE : float_reg_file[rd_phys];
	wire rd_cnd = (rd_phys == 7'h00) ? 1'b1 : condition_flag_file[rd_phys[5:0]];
	wire [81:0] rd_sel = (rd_req.file == ars_pkg::ARS_F_INT) ? {18'h0, rd_int[63:0]} :
		(rd_req.file == ars_pkg::ARS_F_FLT) ? rd_flt :
		(rd_req.file == ars_pkg::ARS_F_CND) ? {81'h0, rd_cnd} :
		{18'h0, jump_target_regs[rd_req.idx[2:0]]};
	wire rd_ok = rd_chk == ars_pkg::ARS_OK;
	// a faulted read returns zero so nothing stale leaks out
	wire [81:0] rd_val = rd_ok ? rd_sel : 82'h0;
	wire rd_tag = rd_ok && rd_req.file == ars_pkg::ARS_F_INT && rd_int[64];

	// write path
	wire [6:0] wr_phys = map_idx(wr_req.file, wr_req.idx, frame_r);
	wire ars_pkg::ars_fault_t wr_chk = chk(wr_req.file, wr_req.idx, 1'b1, wr_req.compat, frame_r);
	wire wr_go = wr_req.valid && wr_chk == ars_pkg::ARS_OK;
	wire wr_int = wr_go && wr_req.file == ars_pkg::ARS_F_INT;
	wire wr_flt = wr_go && wr_req.file == ars_pkg::ARS_F_FLT;
	// condition entry zero swallows writes silently
	wire wr_cnd = wr_go && wr_req.file == ars_pkg::ARS_F_CND && wr_phys != 7'h00;
	wire wr_jmp = wr_go && wr_req.file == ars_pkg::ARS_F_JMP;
	wire [81:0] wr_flt_val = wr_req.tag ? `ARS_FLT_DEFER_VAL : wr_req.data;

	// frame descriptor write check; bits 63:48 are ignored
	wire ars_pkg::ars_frame_t frm_new = frm_data[37:0];
	wire frm_rsvd = |frm_data[`ARS_FRM_RSVD_HI:`ARS_FRM_RSVD_LO];
	wire frm_bad = frm_new.sof > `ARS_STK_MAX || frm_new.sol > frm_new.sof ||
		({3'h0, frm_new.sor} * `ARS_ROT_GROUP) > frm_new.sof ||
		frm_new.rrb_flt >= `ARS_FLT_ROT_SIZE ||
		{1'b0, frm_new.rrb_cnd} >= `ARS_CND_ROT_SIZE;
	wire frm_go = frm_wr && !call && !frm_rsvd && !frm_bad;
	// outputs of the caller become the callee frame
	wire ars_pkg::ars_frame_t frm_call = '{rrb_cnd: 6'h00, rrb_flt: 7'h00, rrb_int: 7'h00,
		sor: 4'h0, sol: 7'h00, sof: frame_r.sof - frame_r.sol};
	wire ars_pkg::ars_frame_t frm_nxt = call ? frm_call : frm_go ? frm_new : frame_r;
	wire ars_pkg::ars_fault_t frm_flt = (!frm_wr || call) ? ars_pkg::ARS_OK :
		(frm_rsvd || frm_bad) ? ars_pkg::ARS_RSVD : ars_pkg::ARS_OK;

	// bundle pointer; branch wins over advance
	wire [31:0] ptr_lin = bundle_pointer_r[31:0] + {28'h0, ptr_len};
	wire [63:0] ptr_step = bundle_pointer_r + `ARS_BUNDLE_STEP;
	wire [63:0] ptr_br = compat_mode ? {32'h0, br_target[31:0]} :
		{br_target[63:4], 4'h0};
	wire [63:0] ptr_seq = compat_mode ? {32'h0, ptr_lin} : {ptr_step[63:4], 4'h0};
	wire [63:0] ptr_nxt = br_taken ? ptr_br : ptr_adv ? ptr_seq : bundle_pointer_r;

	// special register classes
	// class maps held as named words so one bit is picked by index, no wide shift
	wire [127:0] spr_rsvd_map = `ARS_SPR_RSVD_MASK;
	wire [127:0] spr_ign_map = `ARS_SPR_IGN_MASK;
	wire spr_rsvd = spr_rsvd_map[spr_req.idx];
	wire spr_ign = spr_ign_map[spr_req.idx];
	wire spr_ro = spr_req.write && spr_req.idx == `ARS_SPR_RDONLY;
	wire ars_pkg::ars_fault_t spr_flt = !spr_req.valid ? ars_pkg::ARS_OK :
		(spr_rsvd || spr_ro) ? ars_pkg::ARS_ILLEGAL : ars_pkg::ARS_OK;
	// ignored ones are answered here as zero, never forwarded
	wire spr_fwd = spr_req.valid && !spr_rsvd && !spr_ro && !spr_ign;

	// storage updates; a faulted write never touches an entry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			integer_reg_file <= '{default: 65'h0};
			float_reg_file <= '{default: 82'h0};
			condition_flag_file <= '{default: 1'b0};
			jump_target_regs <= '{default: 64'h0};
		end else begin
			if (wr_int)
				integer_reg_file[wr_phys] <= {wr_req.tag, wr_req.data[63:0]};
			if (wr_flt)
				float_reg_file[wr_phys] <= wr_flt_val;
			if (wr_cnd)
				condition_flag_file[wr_phys[5:0]] <= wr_req.data[0];
			if (wr_jmp)
				jump_target_regs[wr_req.idx[2:0]] <= wr_req.data[63:0];
		end
	end

	// read answer and write status, one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_valid_r <= 1'b0;
			rd_data_r <= 82'h0;
			rd_tag_r <= 1'b0;
			rd_fault_r <= ars_pkg::ARS_OK;
			wr_done_r <= 1'b0;
			wr_fault_r <= ars_pkg::ARS_OK;
		end else begin
			rd_valid_r <= rd_req.valid;
			rd_data_r <= rd_val;
			rd_tag_r <= rd_tag;
			rd_fault_r <= rd_req.valid ? rd_chk : ars_pkg::ARS_OK;
			wr_done_r <= wr_req.valid;
			wr_fault_r <= wr_req.valid ? wr_chk : ars_pkg::ARS_OK;
		end
	end

	// frame, pointer and special register status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_r <= '0;
			frm_fault_r <= ars_pkg::ARS_OK;
			bundle_pointer_r <= 64'h0;
			spr_fault_r <= ars_pkg::ARS_OK;
			spr_fwd_r <= 1'b0;
		end else begin
			frame_r <= frm_nxt;
			frm_fault_r <= frm_flt;
			bundle_pointer_r <= ptr_nxt;
			spr_fault_r <= spr_flt;
			spr_fwd_r <= spr_fwd;
		end
	end

	// checks; each antecedent is a request taken on one edge, each consequent its answer
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	int_zero_rd_a: assert property (
		rd_req.valid && !rd_req.compat && rd_req.idx == 7'h00 &&
		rd_req.file == ars_pkg::ARS_F_INT |=> rd_data_r == 82'h0 && !rd_tag_r)
		else $error("integer entry zero read not zero");
	int_zero_wr_a: assert property (
		wr_req.valid && !wr_req.compat && wr_req.idx == 7'h00 &&
		wr_req.file == ars_pkg::ARS_F_INT |=> wr_fault_r == ars_pkg::ARS_ILLEGAL &&
		integer_reg_file[0] == 65'h0)
		else $error("integer entry zero write not refused");
	flt_one_a: assert property (
		rd_req.valid && !rd_req.compat && rd_req.idx == 7'h01 &&
		rd_req.file == ars_pkg::ARS_F_FLT |=> rd_data_r == `ARS_FLT_POS_ONE)
		else $error("float entry one not plus one");
	flt_zero_a: assert property (
		rd_req.valid && !rd_req.compat && rd_req.idx == 7'h00 &&
		rd_req.file == ars_pkg::ARS_F_FLT |=> rd_data_r == `ARS_FLT_POS_ZERO)
		else $error("float entry zero not plus zero");
	flt_dest_a: assert property (
		wr_req.valid && !wr_req.compat && wr_req.idx < 7'h02 &&
		wr_req.file == ars_pkg::ARS_F_FLT |=> wr_fault_r == ars_pkg::ARS_ILLEGAL)
		else $error("float constant entry written");
	cnd_zero_a: assert property (
		rd_req.valid && !rd_req.compat && rd_req.idx == 7'h00 &&
		rd_req.file == ars_pkg::ARS_F_CND |=> rd_data_r[0] && rd_fault_r == ars_pkg::ARS_OK)
		else $error("condition entry zero not one");
	stk_limit_a: assert property (
		rd_req.valid && !rd_req.compat && rd_req.file == ars_pkg::ARS_F_INT &&
		rd_req.idx >= 7'h20 && (rd_req.idx - 7'h20) >= frame_r.sof
		|=> rd_fault_r == ars_pkg::ARS_RSVD)
		else $error("access beyond frame not faulted");
	jmp_range_a: assert property (
		rd_req.valid && !rd_req.compat && rd_req.file == ars_pkg::ARS_F_JMP &&
		rd_req.idx >= 7'h08 |=> rd_fault_r == ars_pkg::ARS_ILLEGAL && rd_data_r == 82'h0)
		else $error("undefined jump target entry not refused");
	compat_wall_a: assert property (
		rd_req.valid && rd_req.compat && rd_req.file == ars_pkg::ARS_F_CND
		|=> rd_fault_r == ars_pkg::ARS_ILLEGAL)
		else $error("legacy access reached a native-only register");
	ptr_step_a: assert property (
		ptr_adv && !br_taken && !compat_mode
		|=> bundle_pointer_r == {$past(bundle_pointer_r[63:4]) + 60'h1, 4'h0})
		else $error("bundle pointer did not step one bundle");
	ptr_align_a: assert property (
		!compat_mode && (br_taken || ptr_adv) |=> bundle_pointer_r[3:0] == 4'h0)
		else $error("native bundle pointer not aligned");
	call_clear_a: assert property (
		call |=> frame_r.rrb_int == 7'h00 && frame_r.rrb_flt == 7'h00 &&
		frame_r.rrb_cnd == 6'h00 && frame_r.sor == 4'h0)
		else $error("call left rename base set");
	frm_rsvd_a: assert property (
		frm_wr && !call && frm_data[47:38] != 10'h0
		|=> frm_fault_r == ars_pkg::ARS_RSVD && frame_r == $past(frame_r))
		else $error("reserved field write not refused");
	frm_enc_a: assert property (
		frm_wr && !call && frm_data[31:25] >= 7'h60
		|=> frm_fault_r == ars_pkg::ARS_RSVD && frame_r == $past(frame_r))
		else $error("undefined rename base accepted");
	spr_class_a: assert property (
		spr_req.valid && spr_req.write && spr_req.idx == 7'h11
		|=> spr_fault_r == ars_pkg::ARS_ILLEGAL && !spr_fwd_r)
		else $error("read-only write not refused");
	spr_rsvd_a: assert property (
		spr_req.valid && spr_req.idx[6:3] == 4'h1
		|=> spr_fault_r == ars_pkg::ARS_ILLEGAL && !spr_fwd_r)
		else $error("reserved special register access not refused");
	spr_ign_a: assert property (
		spr_req.valid && spr_req.idx >= 7'h70
		|=> spr_fault_r == ars_pkg::ARS_OK && !spr_fwd_r)
		else $error("ignored special register not answered here");

	// main scenarios
	call_seen_c: cover property (frm_wr ##1 call ##1 rd_req.valid);
	rot_read_c: cover property (frame_r.rrb_flt != 7'h00 && rd_req.valid &&
		rd_req.file == ars_pkg::ARS_F_FLT && rd_req.idx >= 7'h20);
	branch_c: cover property (ptr_adv ##1 br_taken ##1 ptr_adv);
	compat_read_c: cover property (rd_req.valid && rd_req.compat);
	spr_ign_c: cover property (spr_req.valid && spr_req.idx >= 7'h70);

endmodule : ars_regfile
`default_nettype wire

//--- ars_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none
// pipeline side: operand reads and result writes, one cycle each
module ars_pipe_model (
	// clock
	input wire logic clk,
	// requests toward the register file
	output var ars_pkg::ars_rd_req_t rd_req,
	output var ars_pkg::ars_wr_req_t wr_req
);
	// idle until the first request
	initial begin
		rd_req = '0;
		wr_req = '0;
	end
	// held through the taking edge, then lines turned over so stale values never match
	task automatic rd(input logic [1:0] f, input logic [6:0] i, input logic c);
		@(posedge clk);
		rd_req <= '{1'b1, ars_pkg::ars_file_t'(f), i, c};
		@(posedge clk);
		rd_req <= '{1'b0, ars_pkg::ars_file_t'(~f), ~i, ~c};
		#1;
	endtask : rd
	// callers pass only defined values unless a refusal is wanted
	task automatic wr(input logic [1:0] f, input logic [6:0] i, input logic [81:0] d,
		input logic t, input logic c);
		@(posedge clk);
		wr_req <= '{1'b1, ars_pkg::ars_file_t'(f), i, d, t, c};
		@(posedge clk);
		wr_req <= '{1'b0, ars_pkg::ars_file_t'(~f), ~i, ~d, ~t, ~c};
		#1;
	endtask : wr
endmodule : ars_pipe_model
`default_nettype wire

//--- application_register_state_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ars_consts.svh"
module application_register_state_tb;
	logic clk, rst, frm_wr, call, compat_mode, ptr_adv, br_taken, rd_valid_r, rd_tag_r;
	logic wr_done_r, spr_fwd_r;
	logic [3:0] ptr_len;
	logic [63:0] frm_data, br_target, bundle_pointer_r, exp_p, v;
	logic [81:0] rd_data_r, fv;
	logic [95:0] w96;
	logic [64:0] imem [32];
	ars_pkg::ars_rd_req_t rd_req;
	ars_pkg::ars_wr_req_t wr_req;
	ars_pkg::ars_fault_t rd_fault_r, wr_fault_r, frm_fault_r, spr_fault_r;
	ars_pkg::ars_frame_t frame_r;
	ars_pkg::ars_spr_req_t spr_req;
	int mismatches, compares, seed, cycles, k;
	// device and the pipeline feeding it
	ars_regfile dut_u (.clk(clk), .rst(rst), .rd_req(rd_req), .rd_valid_r(rd_valid_r),
		.rd_data_r(rd_data_r), .rd_tag_r(rd_tag_r), .rd_fault_r(rd_fault_r), .wr_req(wr_req),
		.wr_done_r(wr_done_r), .wr_fault_r(wr_fault_r), .frm_wr(frm_wr), .frm_data(frm_data),
		.call(call), .frame_r(frame_r), .frm_fault_r(frm_fault_r), .compat_mode(compat_mode),
		.ptr_adv(ptr_adv), .ptr_len(ptr_len), .br_taken(br_taken), .br_target(br_target),
		.bundle_pointer_r(bundle_pointer_r), .spr_req(spr_req), .spr_fault_r(spr_fault_r),
		.spr_fwd_r(spr_fwd_r));
	ars_pipe_model pipe_u (.clk(clk), .rd_req(rd_req), .wr_req(wr_req));
	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, far above the roughly 730 cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			mismatches += 1;
			conclude();
		end
	end
	task automatic chk(input string n, input logic [81:0] e, input logic [81:0] g);
		compares += 1;
		if (g !== e) begin
			mismatches += 1;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	// answer stands just after the taking edge
	task automatic rchk(input logic [1:0] f, input logic [6:0] i, input logic c,
		input logic [1:0] ef, input logic [81:0] ed, input logic et);
		pipe_u.rd(f, i, c);
		chk("rd valid", 82'h1, 82'(rd_valid_r));
		chk("rd fault", 82'(ef), 82'(rd_fault_r));
		chk("rd data", ed, rd_data_r);
		chk("rd tag", 82'(et), 82'(rd_tag_r));
	endtask : rchk
	task automatic wchk(input logic [1:0] f, input logic [6:0] i, input logic [81:0] d,
		input logic t, input logic c, input logic [1:0] ef);
		pipe_u.wr(f, i, d, t, c);
		chk("wr done", 82'h1, 82'(wr_done_r));
		chk("wr fault", 82'(ef), 82'(wr_fault_r));
	endtask : wchk
	task automatic frm(input logic [63:0] d, input logic cl, input logic [1:0] ef,
		input logic [37:0] ex);
		@(posedge clk);
		frm_wr <= ~cl;
		call <= cl;
		frm_data <= d;
		@(posedge clk);
		frm_wr <= 1'b0;
		call <= 1'b0;
		frm_data <= ~d;
		#1;
		chk("frame fault", 82'(ef), 82'(frm_fault_r));
		chk("frame", 82'(ex), 82'(frame_r));
	endtask : frm
	// expected pointer kept by the bench
	task automatic ptr(input logic b, input logic [3:0] l);
		v = {$random(seed), $random(seed)};
		if (b) begin
			exp_p = compat_mode ? {32'h0, v[31:0]} : {v[63:4], 4'h0};
		end else begin
			exp_p = compat_mode ? {32'h0, exp_p[31:0] + {28'h0, l}} : exp_p + 64'h10;
		end
		@(posedge clk);
		br_taken <= b;
		ptr_adv <= ~b;
		br_target <= v;
		ptr_len <= l;
		@(posedge clk);
		br_taken <= 1'b0;
		ptr_adv <= 1'b0;
		br_target <= ~v;
		#1;
		chk("pointer", 82'(exp_p), 82'(bundle_pointer_r));
	endtask : ptr
	function automatic logic [37:0] fr(input logic [5:0] rc, input logic [6:0] rf, ri,
		input logic [3:0] so, input logic [6:0] sl, sf);
		return {rc, rf, ri, so, sl, sf};
	endfunction : fr
	// {forwarded, fault} of a special register access
	function automatic logic [2:0] spr_exp(input logic w, input logic [6:0] i);
		if (i inside {[8:15], 20, 22, 23, 31, [33:35], [37:39], [41:43], 46, 47, [67:111]})
			return 3'b001;
		if (w && i == 7'h11)
			return 3'b001;
		if (i inside {[48:63], [112:127]})
			return 3'b000;
		return 3'b100;
	endfunction : spr_exp
	// main sequence
	initial begin
		rst = 1'b1;
		{frm_wr, call, compat_mode, ptr_adv, br_taken, ptr_len} = '0;
		frm_data = '0;
		br_target = '0;
		spr_req = '0;
		seed = 32'h1ED4734F;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("frame", 82'h0, 82'(frame_r));
		chk("pointer", 82'h0, 82'(bundle_pointer_r));
		for (k = 1; k < 32; k++) begin
			v = {$random(seed), $random(seed)};
			imem[k] = {v[0] ^ v[63], v};
			wchk(2'h0, k[6:0], {18'h0, v}, imem[k][64], 1'b0, 2'h0);
		end
		for (k = 1; k < 32; k++)
			rchk(2'h0, k[6:0], 1'b0, 2'h0, {18'h0, imem[k][63:0]}, imem[k][64]);
		wchk(2'h0, 7'h0, {18'h0, v}, 1'b0, 1'b0, 2'h1);
		rchk(2'h0, 7'h0, 1'b0, 2'h0, 82'h0, 1'b0);
		rchk(2'h0, 7'h20, 1'b0, 2'h2, 82'h0, 1'b0);
		$display("test integer file done");
		w96 = {$random(seed), $random(seed), $random(seed)};
		fv = w96[81:0];
		wchk(2'h1, 7'h2, fv, 1'b0, 1'b0, 2'h0);
		rchk(2'h1, 7'h2, 1'b0, 2'h0, fv, 1'b0);
		wchk(2'h1, 7'h7F, fv, 1'b1, 1'b0, 2'h0);
		rchk(2'h1, 7'h7F, 1'b0, 2'h0, `ARS_FLT_DEFER_VAL, 1'b0);
		wchk(2'h1, 7'h1, fv, 1'b0, 1'b0, 2'h1);
		wchk(2'h1, 7'h0, fv, 1'b0, 1'b0, 2'h1);
		rchk(2'h1, 7'h0, 1'b0, 2'h0, `ARS_FLT_POS_ZERO, 1'b0);
		rchk(2'h1, 7'h1, 1'b0, 2'h0, `ARS_FLT_POS_ONE, 1'b0);
		wchk(2'h2, 7'h5, 82'h1, 1'b0, 1'b0, 2'h0);
		rchk(2'h2, 7'h5, 1'b0, 2'h0, 82'h1, 1'b0);
		wchk(2'h2, 7'h0, 82'h0, 1'b0, 1'b0, 2'h0);
		rchk(2'h2, 7'h0, 1'b0, 2'h0, 82'h1, 1'b0);
		rchk(2'h2, 7'h40, 1'b0, 2'h1, 82'h0, 1'b0);
		wchk(2'h3, 7'h7, {18'h0, v}, 1'b0, 1'b0, 2'h0);
		rchk(2'h3, 7'h7, 1'b0, 2'h0, {18'h0, v}, 1'b0);
		rchk(2'h3, 7'h8, 1'b0, 2'h1, 82'h0, 1'b0);
		rchk(2'h0, 7'h8, 1'b1, 2'h0, {18'h0, imem[8][63:0]}, imem[8][64]);
		rchk(2'h0, 7'h7, 1'b1, 2'h1, 82'h0, 1'b0);
		rchk(2'h2, 7'h3, 1'b1, 2'h1, 82'h0, 1'b0);
		$display("test other files done");
		frm({16'hFFFF, 10'h0, fr(0, 0, 0, 1, 4, 16)}, 1'b0, 2'h0, fr(0, 0, 0, 1, 4, 16));
		wchk(2'h0, 7'h21, {18'h0, v}, 1'b0, 1'b0, 2'h0);
		frm({26'h0, fr(0, 0, 1, 1, 4, 16)}, 1'b0, 2'h0, fr(0, 0, 1, 1, 4, 16));
		rchk(2'h0, 7'h20, 1'b0, 2'h0, {18'h0, v}, 1'b0);
		rchk(2'h0, 7'h30, 1'b0, 2'h2, 82'h0, 1'b0);
		frm({16'h0, 10'h4, fr(0, 0, 0, 1, 4, 16)}, 1'b0, 2'h2, fr(0, 0, 1, 1, 4, 16));
		frm({26'h0, fr(0, 96, 0, 1, 4, 16)}, 1'b0, 2'h2, fr(0, 0, 1, 1, 4, 16));
		wchk(2'h2, 7'h10, 82'h1, 1'b0, 1'b0, 2'h0);
		frm({26'h0, fr(47, 0, 0, 1, 4, 16)}, 1'b0, 2'h0, fr(47, 0, 0, 1, 4, 16));
		rchk(2'h2, 7'h11, 1'b0, 2'h0, 82'h1, 1'b0);
		frm({$random(seed), $random(seed)}, 1'b1, 2'h0, fr(0, 0, 0, 0, 0, 12));
		$display("test frame done");
		exp_p = 64'h0;
		ptr(1'b1, 4'h0);
		ptr(1'b0, 4'h0);
		ptr(1'b0, 4'h0);
		@(posedge clk);
		compat_mode <= 1'b1;
		// let the mode settle before the task works out its expectation
		#1;
		ptr(1'b1, 4'h0);
		ptr(1'b0, 4'($random(seed)));
		ptr(1'b0, 4'hF);
		$display("test pointer done");
		for (k = 0; k < 256; k++) begin
			@(posedge clk);
			spr_req <= '{1'b1, k[7], k[6:0]};
			@(posedge clk);
			spr_req <= '{1'b0, ~k[7], ~k[6:0]};
			#1;
			chk("special", 82'(spr_exp(k[7], k[6:0])), 82'({spr_fwd_r, spr_fault_r}));
		end
		$display("test special map done");
		conclude();
	end
endmodule : application_register_state_tb
`default_nettype wire
